// ===== tsp_regs.sv
`timescale 1ns/10ps
`include "tsp_map.svh"

module tsp_regs #(
  parameter int DATA_W = 16
) (
  input wire logic i_clk, // System clock, 200 MHz
  input wire logic i_rst, // Async reset, high
  input wire logic i_ptr_wr, // Pointer byte write strobe
  input wire logic i_data_wr, // Data byte write strobe
  input wire logic [7:0] i_wdata, // Byte from host
  input wire logic i_data_rd, // Data byte read strobe
  input wire logic i_xfer_start, // New data transfer, restart at MSB
  input wire logic i_temp_load, // New conversion result valid
  input wire logic [15:0] i_temp_value, // Conversion result
  input wire logic i_alert_flag, // Live alert bit for settings readback
  output logic [7:0] o_pointer, // Pointer register contents
  output logic [7:0] o_rdata, // Byte returned to host
  output logic o_rvalid, // Read byte valid, one cycle
  output logic [15:0] o_temperature, // Stored temperature result
  output logic [15:0] o_settings, // Operating settings
  output logic [15:0] o_lower_limit, // Lower limit
  output logic [15:0] o_upper_limit // Upper limit
);

  tsp_pkg::tsp_state_t st_q;
  tsp_pkg::tsp_state_t st_d;
  logic [15:0] rw_value [3];
  logic [2:0] rw_wr_en;
  logic [15:0] sel_value;
  logic [15:0] settings_rd;

  // Strobe decode, one winner per cycle
  logic take_ptr;
  logic take_start;
  logic take_wr;
  logic take_rd;

  // Byte path helpers
  logic word_done;
  logic [15:0] wr_word;
  logic [7:0] rd_byte;
  logic [7:0] rd_keep;

  if (DATA_W != `TSP_DATA_W) begin : g_chk
    $error("tsp_regs only supports 16-bit data registers");
  end

  // Bits 0-5, 13 and 14 of the settings word must never take host data
  if ((`TSP_SETTINGS_WMASK & 16'h603f) != 16'h0000) begin : g_chk_ro
    $error("tsp_regs settings write mask covers read-only bits");
  end

  // Reserved settings bits hold fixed values: bit 14 one, the rest zero
  if ((`TSP_SETTINGS_RESET & 16'h601f) != 16'h4000) begin : g_chk_rsv
    $error("tsp_regs reserved settings bits have wrong reset values");
  end

  if (`TSP_SETTINGS_ALERT_BIT >= `TSP_DATA_W) begin : g_chk_alert
    $error("tsp_regs alert bit lies outside the settings word");
  end

  // After reset the host must find the temperature result without a pointer write
  if (`TSP_PTR_RESET != `TSP_PTR_TEMPERATURE) begin : g_chk_ptr
    $error("tsp_regs pointer must reset onto the temperature result");
  end

  if (`TSP_PTR_SETTINGS == `TSP_PTR_TEMPERATURE ||
      `TSP_PTR_LOWER == `TSP_PTR_TEMPERATURE ||
      `TSP_PTR_UPPER == `TSP_PTR_TEMPERATURE ||
      `TSP_PTR_LOWER == `TSP_PTR_SETTINGS ||
      `TSP_PTR_UPPER == `TSP_PTR_SETTINGS ||
      `TSP_PTR_UPPER == `TSP_PTR_LOWER) begin : g_chk_codes
    $error("tsp_regs pointer codes must be distinct");
  end

  // Pointer bits 7:2 are hard zeros; anything else would break read-back
  if (`TSP_PTR_UNUSED_ZERO != 6'h00) begin : g_chk_unused
    $error("tsp_regs upper pointer bits must read as zero");
  end

  // Both limits are plain words the host owns entirely
  if (`TSP_LIMIT_WMASK != 16'hffff) begin : g_chk_limit
    $error("tsp_regs limit registers must be fully writable");
  end

  // Status bit is live, not stored, so the host sees the current alert state
  always_comb begin
    settings_rd = rw_value[0];
    settings_rd[`TSP_SETTINGS_ALERT_BIT] = i_alert_flag;
  end

  always_comb begin
    case (st_q.ptr)
      `TSP_PTR_TEMPERATURE: sel_value = st_q.temperature;
      `TSP_PTR_SETTINGS: sel_value = settings_rd;
      `TSP_PTR_LOWER: sel_value = rw_value[1];
      `TSP_PTR_UPPER: sel_value = rw_value[2];
      default: sel_value = st_q.temperature;
    endcase
  end

  // One strobe is honoured per cycle; a losing strobe is dropped, not queued
  always_comb begin
    take_ptr = i_ptr_wr;
    take_start = i_xfer_start && !i_ptr_wr;
    take_wr = i_data_wr && !i_ptr_wr && !i_xfer_start;
    take_rd = i_data_rd && !i_ptr_wr && !i_xfer_start && !i_data_wr;
  end

  // A word lands only on its second byte, so a lone high byte is discarded
  always_comb begin
    word_done = take_wr && (st_q.phase == tsp_pkg::TSP_PH_LSB);
    wr_word = {st_q.wr_msb, i_wdata};
  end

  // Pointer 0 has no write enable: the bytes are accepted, the word dropped
  always_comb begin
    rw_wr_en = 3'h0;
    if (word_done) begin
      case (st_q.ptr)
        `TSP_PTR_SETTINGS: rw_wr_en[0] = 1'b1;
        `TSP_PTR_LOWER: rw_wr_en[1] = 1'b1;
        `TSP_PTR_UPPER: rw_wr_en[2] = 1'b1;
        default: rw_wr_en = 3'h0;
      endcase
    end
  end

  // Low byte is captured with the high one so the word stays coherent
  always_comb begin
    if (st_q.phase == tsp_pkg::TSP_PH_MSB) begin
      rd_byte = sel_value[15:8];
      rd_keep = sel_value[7:0];
    end else begin
      rd_byte = st_q.rd_lsb;
      rd_keep = st_q.rd_lsb;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.rvalid = take_rd;
    if (i_temp_load) begin
      st_d.temperature = i_temp_value;
    end
    if (take_ptr) begin
      // Upper pointer bits are simply not stored
      st_d.ptr = i_wdata[1:0];
    end
    if (take_ptr || take_start) begin
      st_d.phase = tsp_pkg::TSP_PH_MSB;
    end else if (take_wr || take_rd) begin
      // Reads and writes share one byte phase
      case (st_q.phase)
        tsp_pkg::TSP_PH_MSB: begin
          st_d.phase = tsp_pkg::TSP_PH_LSB;
          if (take_wr) begin
            st_d.wr_msb = i_wdata;
          end
        end
        tsp_pkg::TSP_PH_LSB: st_d.phase = tsp_pkg::TSP_PH_MSB;
        default: st_d.phase = tsp_pkg::TSP_PH_MSB;
      endcase
    end
    if (take_rd) begin
      st_d.rdata = rd_byte;
      st_d.rd_lsb = rd_keep;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q.ptr <= `TSP_PTR_RESET;
      st_q.phase <= tsp_pkg::TSP_PH_MSB;
      st_q.wr_msb <= 8'h00;
      st_q.rd_lsb <= 8'h00;
      st_q.rdata <= 8'h00;
      st_q.rvalid <= 1'b0;
      st_q.temperature <= `TSP_TEMP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Entry 0 is the settings word, 1 the lower limit, 2 the upper limit
  for (genvar i = 0; i < 3; i++) begin : g_rw
    localparam logic [15:0] RST_V = (i == 0) ? `TSP_SETTINGS_RESET : `TSP_LIMIT_RESET;
    localparam logic [15:0] MSK_V = (i == 0) ? `TSP_SETTINGS_WMASK : `TSP_LIMIT_WMASK;
    tsp_rw_reg #(
      .WIDTH(DATA_W),
      .RESET_VAL(RST_V),
      .WMASK(MSK_V)
    ) u_reg (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_wr_en(rw_wr_en[i]),
      .i_wdata(wr_word),
      .o_value(rw_value[i])
    );
  end

  assign o_pointer = {`TSP_PTR_UNUSED_ZERO, st_q.ptr};
  assign o_rdata = st_q.rdata;
  assign o_rvalid = st_q.rvalid;
  assign o_temperature = st_q.temperature;
  assign o_settings = rw_value[0];
  assign o_lower_limit = rw_value[1];
  assign o_upper_limit = rw_value[2];

endmodule

// ===== tsp_map.svh
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// Pointer values selecting each data register
`define TSP_PTR_TEMPERATURE 2'h0
`define TSP_PTR_SETTINGS 2'h1
`define TSP_PTR_LOWER 2'h2
`define TSP_PTR_UPPER 2'h3
`define TSP_PTR_RESET 2'h0
`define TSP_PTR_UNUSED_ZERO 6'h00

// Data register layouts and reset values
`define TSP_DATA_W 16
`define TSP_SETTINGS_RESET 16'h40a0
`define TSP_SETTINGS_WMASK 16'h9fc0
`define TSP_SETTINGS_ALERT_BIT 5
`define TSP_LIMIT_RESET 16'h0000
`define TSP_LIMIT_WMASK 16'hffff
`define TSP_TEMP_RESET 16'h0000

`endif

// ===== tsp_pkg.sv
package tsp_pkg;

  typedef enum logic {
    TSP_PH_MSB,
    TSP_PH_LSB
  } tsp_phase_t;

  typedef struct packed {
    logic [1:0] ptr;
    tsp_phase_t phase;
    logic [7:0] wr_msb;
    logic [7:0] rd_lsb;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] temperature;
  } tsp_state_t;

  typedef struct packed {
    logic [15:0] value;
  } tsp_reg_state_t;

endpackage

// ===== tsp_rw_reg.sv
`timescale 1ns/10ps
`include "tsp_map.svh"

module tsp_rw_reg #(
  parameter int WIDTH = 16,
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WMASK = 16'hffff
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_wr_en, // Commit a full word
  input wire logic [15:0] i_wdata, // Assembled word
  output logic [15:0] o_value // Stored word
);

  tsp_pkg::tsp_reg_state_t st_q;
  tsp_pkg::tsp_reg_state_t st_d;

  if (WIDTH != `TSP_DATA_W) begin : g_chk
    $error("tsp_rw_reg only supports a 16-bit width");
  end

  always_comb begin
    st_d = st_q;
    if (i_wr_en) begin
      // Read-only positions keep their stored value
      st_d.value = (i_wdata & WMASK) | (st_q.value & ~WMASK);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q.value <= RESET_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_value = st_q.value;

endmodule

// ===== tsp_regs_properties.sv
`timescale 1ns/10ps
module tsp_regs_checker (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_ptr_wr, // Pointer strobe
  input wire logic i_data_wr, // Data strobe
  input wire logic i_data_rd, // Read strobe
  input wire logic i_xfer_start, // Start strobe
  input wire logic [7:0] i_wdata, // Byte in
  input wire logic i_temp_load, // Result strobe
  input wire logic [15:0] i_temp_value, // Result
  input wire logic [7:0] o_pointer, // Pointer
  input wire logic o_rvalid, // Read valid
  input wire logic [15:0] o_temperature, // Temperature
  input wire logic [15:0] o_settings, // Settings
  input wire logic [15:0] o_upper_limit // Upper limit
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ptr_high_zero: assert property (o_pointer[7:2] == 6'h00)
    else $error("pointer high bits set");
  a_ptr_load: assert property (i_ptr_wr |=> o_pointer[1:0] == $past(i_wdata[1:0]))
    else $error("pointer not loaded");
  a_ptr_keep: assert property (!i_ptr_wr |=> $stable(o_pointer))
    else $error("pointer moved");
  a_read_cause: assert property (o_rvalid |-> $past(i_data_rd) && !$past(i_ptr_wr) &&
    !$past(i_xfer_start) && !$past(i_data_wr)) else $error("read byte without request");
  a_temp_load: assert property (i_temp_load |=> o_temperature == $past(i_temp_value))
    else $error("result not stored");
  a_temp_keep: assert property (!i_temp_load |=> $stable(o_temperature))
    else $error("result changed by host");
  a_set_route: assert property ($changed(o_settings[15:6]) |->
    $past(o_pointer[1:0]) == 2'h1 && $past(i_data_wr)) else $error("settings misrouted");
  a_upper_route: assert property ($changed(o_upper_limit) |->
    $past(o_pointer[1:0]) == 2'h3) else $error("upper limit misrouted");
  a_set_fixed: assert property (o_settings[14:13] == 2'h2 && o_settings[4:0] == 5'h00)
    else $error("settings fixed bits changed");
  c_ptr_then_data: cover property (i_ptr_wr ##[1:8] i_data_wr);
  c_read_pair: cover property (o_rvalid ##2 o_rvalid);
  c_upper_write: cover property ($changed(o_upper_limit));
endmodule
bind tsp_regs tsp_regs_checker chk (.i_clk, .i_rst, .i_ptr_wr, .i_data_wr, .i_data_rd,
  .i_xfer_start,
  .i_wdata, .i_temp_load, .i_temp_value, .o_pointer, .o_rvalid, .o_temperature,
  .o_settings, .o_upper_limit);

// ===== tsp_host.sv
`timescale 1ns/10ps
module tsp_host (
  input wire logic i_clk, // Bus clock
  output logic o_ptr_wr, // Pointer byte strobe
  output logic o_data_wr, // Data byte strobe
  output logic o_data_rd, // Read strobe
  output logic o_start, // Transfer start
  output logic [7:0] o_byte // Byte to device
);
  initial {o_ptr_wr, o_data_wr, o_data_rd, o_start, o_byte} = 12'h000;
  task op(input logic [3:0] s, input logic [7:0] b);
    @(negedge i_clk);
    {o_ptr_wr, o_data_wr, o_data_rd, o_start} = s;
    o_byte = b;
    @(negedge i_clk);
    {o_ptr_wr, o_data_wr, o_data_rd, o_start} = 4'h0;
    o_byte = ~b; // Released byte lines must not look held
  endtask
  task acc(input logic [1:0] p, input logic [5:0] junk, input logic [15:0] w, input logic wr);
    op(4'h8, {junk, p});
    op(4'h1, 8'h00);
    op(wr ? 4'h4 : 4'h2, w[15:8]);
    op(wr ? 4'h4 : 4'h2, w[7:0]);
  endtask
endmodule

// ===== tsp_regs_bench.sv
`timescale 1ns/10ps
module tsp_regs_bench;
  logic i_clk = 0, i_rst = 1, i_temp_load = 0, i_alert_flag = 1;
  logic i_ptr_wr, i_data_wr, i_data_rd, i_xfer_start, o_rvalid;
  logic [15:0] o_temperature, o_settings, o_lower_limit, o_upper_limit;
  logic [7:0] i_wdata, o_pointer, o_rdata;
  logic [15:0] i_temp_value = 16'h0000, w;
  logic [15:0] img [4] = '{16'h0000, 16'h40a0, 16'h0000, 16'h0000};
  logic [7:0] exp_q [$];
  logic [1:0] p;
  int failures = 0, samples_checked = 0;
  always #2.5 i_clk = ~i_clk;
  tsp_host h (.i_clk, .o_ptr_wr(i_ptr_wr), .o_data_wr(i_data_wr), .o_data_rd(i_data_rd),
    .o_start(i_xfer_start), .o_byte(i_wdata));
  tsp_regs dut (.i_clk, .i_rst, .i_ptr_wr, .i_data_wr, .i_wdata, .i_data_rd, .i_xfer_start,
    .i_temp_load, .i_temp_value, .i_alert_flag, .o_pointer, .o_rdata, .o_rvalid,
    .o_temperature, .o_settings, .o_lower_limit, .o_upper_limit);
  task chk(input string n, input logic [15:0] e, input logic [15:0] v);
    samples_checked++;
    if (v !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task chk_regs;
    chk("temperature", img[0], o_temperature);
    chk("settings", img[1], o_settings);
    chk("lower limit", img[2], o_lower_limit);
    chk("upper limit", img[3], o_upper_limit);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task acc(input logic [1:0] a, input logic [15:0] d, input logic wr);
    logic [15:0] e;
    e = img[a];
    if (a == 2'h1) e[5] = i_alert_flag; // Alert bit is live on reads
    if (!wr) begin
      exp_q.push_back(e[15:8]);
      exp_q.push_back(e[7:0]);
    end
    h.acc(a, 6'($urandom), d, wr);
  endtask
  always @(negedge i_clk) begin
    if (o_rvalid === 1'b1) begin
      chk("read byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, o_rdata);
    end
  end
  initial begin
    void'($urandom(89));
    repeat (8) @(negedge i_clk);
    i_rst = 0;
    chk("pointer", 16'h0000, {8'h00, o_pointer});
    chk_regs;
    for (int k = 0; k < 4; k++) acc(2'(k), 16'h0000, 1'b0);
    for (int k = 0; k < 12; k++) begin
      @(negedge i_clk);
      i_temp_value = 16'($urandom);
      i_temp_load = 1;
      i_alert_flag = 1'($urandom);
      img[0] = i_temp_value;
      @(negedge i_clk);
      i_temp_load = 0;
      p = 2'(k);
      w = 16'($urandom);
      acc(p, w, 1'b1);
      chk("pointer", {14'h0000, p}, {8'h00, o_pointer});
      if (p == 2'h1) img[1] = (w & 16'h9fc0) | 16'h4020;
      else if (p != 2'h0) img[p] = w;
      chk_regs;
      acc(2'($urandom), w, 1'b0);
    end
    repeat (4) @(negedge i_clk);
    i_rst = 1; // Mid-run reset must bring every register back
    repeat (2) @(negedge i_clk);
    i_rst = 0;
    img = '{16'h0000, 16'h40a0, 16'h0000, 16'h0000};
    chk("pointer", 16'h0000, {8'h00, o_pointer});
    chk_regs;
    for (int k = 0; k < 4; k++) acc(2'(k), 16'h0000, 1'b0);
    repeat (4) @(negedge i_clk);
    chk("reads answered", 16'h0000, 16'(exp_q.size()));
    stop_test;
  end
  initial begin
    #50000;
    failures++;
    stop_test;
  end
endmodule
